// ---- hw/spi_pkg.sv ----
// Package with constants and types for the stepper pulse interface.
package spi_pkg;
  // Logic clock rate and the enable-to-ready delay.
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned READY_DELAY_MS = 500;
  localparam int unsigned READY_DELAY_CYC = (CLK_HZ / 1000) * READY_DELAY_MS;
  // Duty measurement window: one period of the slowest allowed PWM, 10 kHz.
  localparam int unsigned PWM_MIN_HZ = 10_000;
  localparam int unsigned PWM_WIN_CYC = CLK_HZ / PWM_MIN_HZ;
  // Phase ring length of a three-phase stage (six half steps).
  localparam int unsigned RING_LEN = 6;
  localparam int unsigned DUTY_W = 8;
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  // Register map of the Avalon-MM slave, word addresses.
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_STAT = 3'h1;
  localparam logic [2:0] ADDR_IRQ = 3'h2;
  localparam logic [2:0] ADDR_MASK = 3'h3;
  localparam logic [2:0] ADDR_POS = 3'h4;
  localparam logic [2:0] ADDR_DUTY = 3'h5;
  localparam logic [31:0] DEAD_READ = 32'h0000_0000;
  // Control register bits: software disable and fault clear.
  localparam int unsigned CTRL_OFF_BIT = 0;
  localparam int unsigned CTRL_CLR_BIT = 1;
  // Interrupt status bit positions.
  localparam int unsigned IRQ_READY = 0;
  localparam int unsigned IRQ_FAULT = 1;
  localparam int unsigned IRQ_ZERO = 2;
  localparam int unsigned IRQ_STILL = 3;
  localparam int unsigned IRQ_W = 4;
  typedef enum logic [1:0] {ST_OFF, ST_WAIT, ST_READY, ST_FAULT} spi_state_type;
endpackage

// ---- hw/spi_sync.sv ----
// Two flip-flop synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ps
module spi_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // Data
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule

// ---- hw/spi_top.sv ----
// Step pulse interface of a three-phase stepping motor stage.
// What this block does
// - Each rising step edge advances one step only when ready and gate high.
// - Sense low turns clockwise, sense high counterclockwise.
// - About 500 ms after enable, both readiness outputs assert and phases energize.
// - Current-control duty from 0 to 100 percent at 10-20 kHz scales current.
// - Current-control low gives set current; high switches phase current off.
// - Low-active readiness conducts when ready, floats on fault or no enable.
// - Gate low ignores steps, holds shaft, acknowledges standstill; gate high releases.
// - Ring-zero output asserts one cycle after the phase ring counter is zero; reset holds it low.
//
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module spi_top
  import spi_pkg::*;
#(
  parameter int unsigned READY_CYC = READY_DELAY_CYC,
  parameter int unsigned POS_W = 32
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // Pulse and signal interface inputs
  input wire logic i_step_pulse,
  input wire logic i_rot_sense,
  input wire logic i_stage_enable,
  input wire logic i_current_off,
  input wire logic i_pulse_gate,
  input wire logic i_stage_fault,
  // Pulse and signal interface outputs
  output logic o_ready_low_active_out,
  output logic o_ready_low_active_out_oe_n,
  output logic o_ready_high_active_out,
  output logic o_standstill_ack_out,
  output logic o_ring_zero,
  output logic o_phase_en,
  output logic [2:0] o_phase_sel,
  output logic [DUTY_W-1:0] o_phase_duty,
  output logic o_step_taken,
  // Avalon-MM slave
  input wire logic [2:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Interrupt
  output logic o_irq
);
  localparam logic [31:0] READY_LAST = 32'(READY_CYC - 1);
  localparam logic [15:0] WIN_LAST = 16'(PWM_WIN_CYC - 1);
  localparam logic [2:0] RING_LAST = 3'(RING_LEN - 1);

  logic [5:0] in_sync;
  logic pulse_s, sense_s, enable_s, off_s, gate_s, fault_s;
  logic pulse_d1_q;
  logic step_rise;
  spi_state_type state_q;
  logic [31:0] wait_cnt_q;
  logic [2:0] ring_q;
  logic [POS_W-1:0] pos_q;
  logic [15:0] win_cnt_q;
  logic [15:0] on_cnt_q;
  logic [DUTY_W-1:0] duty_q;
  logic ready;
  logic ack_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_evt;
  logic sw_disable_q;
  logic [31:0] rdata;
  logic rd_irq;
  logic zero_q;
  logic fault_clr;
  logic cur_on;
  logic rd_done_q;

  spi_sync #(.WIDTH(6)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_async({i_stage_fault, i_pulse_gate, i_current_off, i_stage_enable, i_rot_sense, i_step_pulse}),
    .o_sync(in_sync)
  );
  assign {fault_s, gate_s, off_s, enable_s, sense_s, pulse_s} = in_sync;

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      pulse_d1_q <= 1'b0;
    else
      pulse_d1_q <= pulse_s;
  end
  assign step_rise = pulse_s & ~pulse_d1_q;

  // Enable, delay, ready and fault sequencing.
  assign fault_clr = i_avs_write && !o_avs_waitrequest && i_avs_address == ADDR_CTRL && i_avs_writedata[CTRL_CLR_BIT];
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_q <= ST_OFF;
      wait_cnt_q <= '0;
    end
    else
    begin
      unique case (state_q)
        ST_OFF:
        begin
          wait_cnt_q <= '0;
          if (enable_s && !sw_disable_q)
            state_q <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (!enable_s || sw_disable_q)
            state_q <= ST_OFF;
          else if (fault_s)
            state_q <= ST_FAULT;
          else if (wait_cnt_q == READY_LAST)
            state_q <= ST_READY;
          else
            wait_cnt_q <= wait_cnt_q + 32'h0000_0001;
        end
        ST_READY:
        begin
          if (fault_s)
            state_q <= ST_FAULT;
          else if (!enable_s || sw_disable_q)
            state_q <= ST_OFF;
        end
        ST_FAULT:
        begin
          if (!enable_s || fault_clr)
            state_q <= ST_OFF;
        end
      endcase
    end
  end
  assign ready = state_q == ST_READY;

  // Readiness pins: open collector conducts only when ready.
  assign o_ready_low_active_out = 1'b0;
  assign o_ready_low_active_out_oe_n = ~ready;
  assign o_ready_high_active_out = ready;
  assign o_phase_en = ready & ~off_s;

  // Step counting and phase ring. Pulses outside ready and gate are ignored.
  assign o_step_taken = step_rise & ready & gate_s;
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ring_q <= '0;
      pos_q <= '0;
    end
    else if (o_step_taken)
    begin
      if (!sense_s)
      begin
        ring_q <= (ring_q == RING_LAST) ? 3'h0 : ring_q + 3'h1;
        pos_q <= pos_q + POS_W'(1);
      end
      else
      begin
        ring_q <= (ring_q == 3'h0) ? RING_LAST : ring_q - 3'h1;
        pos_q <= pos_q - POS_W'(1);
      end
    end
  end
  assign o_phase_sel = ring_q;

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_ring_zero <= 1'b0;
      o_standstill_ack_out <= 1'b1;
      // The ring starts at zero, so the edge detector starts high to avoid a false event.
      zero_q <= 1'b1;
    end
    else
    begin
      o_ring_zero <= ring_q == 3'h0;
      o_standstill_ack_out <= ~gate_s;
      zero_q <= ring_q == 3'h0;
    end
  end

  // Duty measurement of the current-control input over a fixed window.
  // Current flows while the input is low, so low time sets the duty.
  // A one-bit helper keeps the inversion from being widened by the casts below.
  assign cur_on = ~off_s;
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      win_cnt_q <= '0;
      on_cnt_q <= '0;
      duty_q <= '0;
    end
    else if (win_cnt_q == WIN_LAST)
    begin
      win_cnt_q <= '0;
      on_cnt_q <= '0;
      duty_q <= DUTY_W'(((32'(on_cnt_q) + 32'(cur_on)) * 32'(DUTY_FULL)) / 32'(PWM_WIN_CYC));
    end
    else
    begin
      win_cnt_q <= win_cnt_q + 16'h0001;
      on_cnt_q <= on_cnt_q + 16'(cur_on);
    end
  end

  // Phase current is off outright while the input is high or the stage is not ready, else scaled.
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_phase_duty <= '0;
    else if (!ready || off_s)
      o_phase_duty <= '0;
    else
      o_phase_duty <= (duty_q == '0) ? DUTY_FULL : duty_q;
  end

  // Interrupt events, sticky until the status register is read.
  assign irq_evt[IRQ_READY] = state_q == ST_WAIT && wait_cnt_q == READY_LAST && enable_s && !sw_disable_q
    && !fault_s;
  assign irq_evt[IRQ_FAULT] = fault_s && (state_q == ST_WAIT || state_q == ST_READY);
  assign irq_evt[IRQ_ZERO] = (ring_q == 3'h0) && !zero_q;
  assign irq_evt[IRQ_STILL] = ~gate_s & ~o_standstill_ack_out;
  // Status clears at the edge that captures it, so an event in the wait cycle is kept.
  assign rd_irq = i_avs_read && !rd_done_q && i_avs_address == ADDR_IRQ;

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      irq_stat_q <= '0;
    else
      irq_stat_q <= (rd_irq ? '0 : irq_stat_q) | irq_evt;
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      irq_mask_q <= '0;
      sw_disable_q <= 1'b0;
    end
    else if (i_avs_write && !o_avs_waitrequest)
    begin
      if (i_avs_address == ADDR_MASK)
        irq_mask_q <= i_avs_writedata[IRQ_W-1:0];
      if (i_avs_address == ADDR_CTRL)
        sw_disable_q <= i_avs_writedata[CTRL_OFF_BIT];
    end
  end
  assign o_irq = |(irq_stat_q & irq_mask_q);

  // Register bus: writes finish at once; reads take one wait state so that
  // the registered read data stand at the edge where the master accepts them.
  assign o_avs_waitrequest = i_avs_read & ~rd_done_q;
  always_comb
  begin
    rdata = DEAD_READ;
    unique case (i_avs_address)
      ADDR_CTRL: rdata = {31'h0000_0000, sw_disable_q};
      ADDR_STAT: rdata = {24'h00_0000, off_s, gate_s, enable_s, sense_s, ring_q == 3'h0, 1'b0, state_q};
      ADDR_IRQ: rdata = {28'h000_0000, irq_stat_q};
      ADDR_MASK: rdata = {28'h000_0000, irq_mask_q};
      ADDR_POS: rdata = 32'(pos_q);
      ADDR_DUTY: rdata = {24'h00_0000, duty_q};
      default: rdata = DEAD_READ;
    endcase
  end
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rd_done_q <= 1'b0;
    else
      rd_done_q <= i_avs_read & ~rd_done_q;
  end
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_avs_readdata <= '0;
    else if (i_avs_read && !rd_done_q)
      o_avs_readdata <= rdata;
  end
endmodule

// ---- test/spi_ctrl_model.sv ----
// Controller model: gated step pulse trains and a 10 kHz current-control signal.
`timescale 1ns/1ps
module spi_ctrl_model (
  // Clock and requests
  input wire logic i_ref_clk,
  input wire logic i_allowed,
  input wire logic i_go,
  input wire logic [7:0] i_steps,
  input wire logic [11:0] i_pwm_hi,
  // Stage inputs
  output logic o_step,
  output logic o_pwm,
  output logic o_busy
);
  logic [7:0] left_q = 8'h00;
  logic [2:0] ph_q = 3'h0;
  logic [11:0] cyc_q = 12'h000;
  assign o_busy = left_q != 8'h00;
  assign o_step = ph_q[1:0] != 2'b00 && !ph_q[2];
  assign o_pwm = cyc_q < i_pwm_hi;
  always @(posedge i_ref_clk)
  begin
    cyc_q <= (cyc_q == 12'hF9F) ? 12'h000 : cyc_q + 12'h001;
    if (i_go)
      left_q <= i_steps;
    else if (o_busy && i_allowed)
    begin
      ph_q <= ph_q + 3'h1;
      if (ph_q == 3'h7)
        left_q <= left_q - 8'h01;
    end
  end
endmodule

// ---- test/spi_tb.sv ----
// Self-checking bench for the stepper pulse interface.
`timescale 1ns/1ps
module testbench import spi_pkg::*;;
  logic i_ref_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_rot_sense = 1'b0;
  logic i_stage_enable = 1'b0;
  logic i_pulse_gate = 1'b0;
  logic i_stage_fault = 1'b0;
  logic [2:0] i_avs_address = 3'h0;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0000_0000;
  logic o_ready_low_active_out_oe_n, o_ready_high_active_out, o_standstill_ack_out, o_ring_zero, o_phase_en;
  logic o_ready_low_active_out;
  logic o_step_taken, o_avs_waitrequest, o_irq, i_step_pulse, i_current_off, busy;
  logic [2:0] o_phase_sel;
  logic [7:0] o_phase_duty;
  logic [31:0] o_avs_readdata, rdv;
  logic frc = 1'b0;
  logic go = 1'b0;
  logic [7:0] steps = 8'h00;
  logic [11:0] pwm_hi = 12'h000;
  int n_mismatch = 0;
  int compares = 0;
  int n_steps = 0;
  always #12.5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk)
    if (o_step_taken === 1'b1)
      n_steps++;
  spi_ctrl_model ctrl_u (.i_ref_clk, .i_allowed(frc | (o_ready_high_active_out & i_pulse_gate)), .i_go(go),
    .i_steps(steps), .i_pwm_hi(pwm_hi), .o_step(i_step_pulse), .o_pwm(i_current_off), .o_busy(busy));
  spi_top #(.READY_CYC(20)) dut_u (.i_ref_clk, .i_arst_n, .i_step_pulse, .i_rot_sense, .i_stage_enable,
    .i_current_off, .i_pulse_gate, .i_stage_fault, .o_ready_low_active_out, .o_ready_low_active_out_oe_n,
    .o_ready_high_active_out, .o_standstill_ack_out, .o_ring_zero, .o_phase_en, .o_phase_sel, .o_phase_duty,
    .o_step_taken, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata,
    .o_avs_waitrequest, .o_irq);
  task automatic results();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge i_ref_clk);
  endtask
  task automatic limit(input int k);
    if (k >= 999)
    begin
      n_mismatch++;
      results();
    end
  endtask
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    int k;
    k = 0;
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= w;
    i_avs_read <= !w;
    do
    begin
      tick(1);
      k++;
    end
    while (o_avs_waitrequest !== 1'b0 && k < 999);
    rdv = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    tick(1);
    limit(k);
  endtask
  task automatic run(input logic [7:0] cnt, input int exp);
    int k;
    k = 0;
    n_steps = 0;
    steps <= cnt;
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(1);
    while (busy === 1'b1 && k < 999)
    begin
      tick(1);
      k++;
    end
    limit(k);
    tick(6);
    chk("steps", exp, n_steps);
  endtask
  initial
  begin
    int k;
    tick(3);
    i_arst_n <= 1'b1;
    tick(1);
    chk("oe_n", 1, o_ready_low_active_out_oe_n);
    chk("still", 1, o_standstill_ack_out);
    bus(1, ADDR_MASK, 32'h0000_000D);
    i_stage_enable <= 1'b1;
    k = 0;
    while (o_ready_high_active_out !== 1'b1 && k < 999)
    begin
      tick(1);
      k++;
    end
    limit(k);
    chk("delay", 1, k >= 20 && k < 27);
    chk("oe_n", 0, o_ready_low_active_out_oe_n);
    chk("rdy drive", 0, o_ready_low_active_out);
    chk("phase", 1, o_phase_en);
    chk("irq", 1, o_irq);
    bus(0, ADDR_IRQ, 0);
    chk("irq rdy", 1, rdv[0]);
    chk("irq", 0, o_irq);
    pwm_hi <= 12'hFA0;
    tick(6);
    chk("off", 0, o_phase_en);
    pwm_hi <= 12'h3E8;
    tick(10000);
    bus(0, ADDR_DUTY, 0);
    chk("duty reg", 32'h0000_00BF, rdv);
    k = 0;
    while (o_phase_en !== 1'b1 && k < 999)
    begin
      tick(2);
      k++;
    end
    limit(k);
    tick(1);
    chk("duty", 8'hBF, o_phase_duty);
    pwm_hi <= 12'h000;
    $display("ready test done");
    i_pulse_gate <= 1'b1;
    tick(4);
    chk("still", 0, o_standstill_ack_out);
    run(7, 7);
    bus(0, ADDR_POS, 0);
    chk("pos", 7, rdv);
    chk("sel", 1, o_phase_sel);
    i_rot_sense <= 1'b1;
    run(8, 8);
    bus(0, ADDR_POS, 0);
    chk("pos", 32'hFFFF_FFFF, rdv);
    chk("sel", 5, o_phase_sel);
    i_pulse_gate <= 1'b0;
    frc <= 1'b1;
    tick(4);
    chk("still", 1, o_standstill_ack_out);
    run(3, 0);
    chk("irq", 1, o_irq);
    bus(0, ADDR_IRQ, 0);
    chk("irq evts", 32'h0000_000C, rdv);
    $display("step test done");
    i_stage_fault <= 1'b1;
    i_pulse_gate <= 1'b1;
    tick(6);
    chk("oe_n", 1, o_ready_low_active_out_oe_n);
    chk("irq", 0, o_irq);
    run(2, 0);
    bus(1, ADDR_MASK, 32'h0000_000F);
    chk("irq", 1, o_irq);
    bus(0, ADDR_IRQ, 0);
    chk("irq flt", 1, rdv[1]);
    chk("irq", 0, o_irq);
    bus(1, 3'h7, 32'hFFFF_FFFF);
    bus(0, 3'h6, 0);
    chk("unmapped", 0, rdv);
    $display("fault test done");
    i_stage_fault <= 1'b0;
    tick(4);
    bus(1, ADDR_CTRL, 32'h0000_0002);
    k = 0;
    while (o_ready_high_active_out !== 1'b1 && k < 999)
    begin
      tick(1);
      k++;
    end
    limit(k);
    chk("rearm", 1, k >= 20 && k < 27);
    bus(0, ADDR_STAT, 0);
    chk("stat", 32'h0000_0072, rdv);
    bus(1, ADDR_CTRL, 32'h0000_0001);
    tick(2);
    chk("oe_n", 1, o_ready_low_active_out_oe_n);
    chk("ready", 0, o_ready_high_active_out);
    $display("control test done");
    results();
  end
endmodule

// ---- test/spi_top_sva.sv ----
// Assertion checker bound to the stepper pulse interface top.
`timescale 1ns/1ps
module spi_top_sva #(
  parameter int unsigned READY_CYC = 20
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // Watched ports
  input wire logic i_rot_sense,
  input wire logic i_stage_enable,
  input wire logic i_pulse_gate,
  input wire logic o_ready_low_active_out_oe_n,
  input wire logic o_ready_high_active_out,
  input wire logic o_standstill_ack_out,
  input wire logic o_ring_zero,
  input wire logic [2:0] o_phase_sel,
  input wire logic o_step_taken
);
  int unsigned en_cnt_q;
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
    if (!i_arst_n)
      en_cnt_q <= 0;
    else
      en_cnt_q <= i_stage_enable ? en_cnt_q + 1 : 0;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  a_ready_pins: assert property (o_ready_low_active_out_oe_n == !o_ready_high_active_out)
    else $error("ready pins disagree");
  a_ready_delay: assert property ($rose(o_ready_high_active_out) |-> en_cnt_q >= READY_CYC)
    else $error("ready too early");
  a_step_single: assert property (o_step_taken |=> !o_step_taken)
    else $error("step pulse too long");
  a_step_cw: assert property (o_step_taken && !$past(i_rot_sense, 2) |=>
    o_phase_sel == ($past(o_phase_sel) == 3'h5 ? 3'h0 : $past(o_phase_sel) + 3'h1)) else $error("bad cw step");
  a_step_ccw: assert property (o_step_taken && $past(i_rot_sense, 2) |=>
    o_phase_sel == ($past(o_phase_sel) == 3'h0 ? 3'h5 : $past(o_phase_sel) - 3'h1)) else $error("bad ccw step");
  a_ring_hold: assert property (!o_step_taken |=> $stable(o_phase_sel))
    else $error("ring moved without step");
  a_ring_zero: assert property ($past(i_arst_n, 2) |-> o_ring_zero == ($past(o_phase_sel) == 3'h0))
    else $error("ring zero wrong");
  a_still_on: assert property (!i_pulse_gate [*4] |-> o_standstill_ack_out)
    else $error("standstill not acknowledged");
  a_still_off: assert property (i_pulse_gate [*4] |-> !o_standstill_ack_out)
    else $error("standstill not released");
  c_ccw: cover property (o_step_taken && i_rot_sense);
  c_zero: cover property (o_step_taken && o_ring_zero);
  c_drop: cover property ($fell(o_ready_high_active_out));
endmodule
bind spi_top spi_top_sva #(.READY_CYC(READY_CYC)) sva_u (.i_ref_clk, .i_arst_n, .i_rot_sense, .i_stage_enable,
  .i_pulse_gate, .o_ready_low_active_out_oe_n, .o_ready_high_active_out, .o_standstill_ack_out, .o_ring_zero,
  .o_phase_sel, .o_step_taken);
